// ==== bench/apscd_decoder_bench.sv ====
// self-checking bench for the strap configuration decoder
// assumes the strap model drives all device pins
`timescale 1ns/1ps
`default_nettype none
module apscd_decoder_bench;
	import apscd_pkg::*;
	// ==========
	// signals
	logic clk, resetn, hold, reset_pin_n, analog_supply_ok, digital_supply_ok;
	logic device_in_reset, sw_mode, config_valid, format_invalid, rate_detect_ok;
	logic [1:0] hold_src, s_axi_bresp, s_axi_rresp, rsp;
	logic [2:0] mode_lvl, fmt_lvl, rate_lvl, mode_rate_strap, frame_format_strap, detected_rate_code;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb;
	apscd_port_cfg_type port_cfg, exp_cfg;
	integer error_cnt, checks_done, seed, n;
	apscd_decoder uut (.clk, .resetn, .reset_pin_n, .analog_supply_ok, .digital_supply_ok,
		.mode_rate_strap, .frame_format_strap, .detected_rate_code, .device_in_reset, .sw_mode,
		.config_valid, .format_invalid, .rate_detect_ok, .port_cfg, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	apscd_strap_model u_strap (.clk, .hold, .hold_src, .mode_lvl, .fmt_lvl, .rate_lvl,
		.reset_pin_n, .analog_supply_ok, .digital_supply_ok, .mode_rate_strap,
		.frame_format_strap, .detected_rate_code);
	// 20 MHz clock
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// ==========
	// helpers
	task automatic chk(input logic ok, input string what);
		checks_done++;
		if (ok !== 1'b1) begin
			error_cnt++;
			$display("[FAIL] %0t %s", $time, what);
		end
	endtask : chk
	task automatic axw(input logic [31:0] a, input logic [31:0] d);
		s_axi_awaddr  <= a;
		s_axi_wdata   <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1 && n < 40);
		chk(s_axi_bvalid === 1'b1, "write answer");
		rsp = s_axi_bresp;
		s_axi_bready <= 1'b0;
		@(posedge clk);
	endtask : axw
	task automatic axr(input logic [31:0] a);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1 && n < 40);
		chk(s_axi_rvalid === 1'b1, "read answer");
		rd = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge clk);
	endtask : axr
	// expected hardware configuration from the strap levels
	function automatic apscd_port_cfg_type expect_cfg(input logic [2:0] m, input logic [2:0] f);
		apscd_port_cfg_type c;
		c = '0;
		c.role_secondary  = m[2];
		c.rate_autodetect = (m == 3'h7);
		c.rate_family     = (m == 3'h2 || m == 3'h5) ? 2'h1 : (m == 3'h3 || m == 3'h4) ? 2'h2 : 2'h0;
		c.tdm_max_slots   = (f == 3'h1 || f == 3'h2);
		c.launch_rising   = (f == 3'h2);
		c.frame_format    = (f < 3'h3) ? 2'h0 : (f == 3'h6) ? 2'h1 : (f == 3'h7) ? 2'h2 : 2'h3;
		return c;
	endfunction : expect_cfg
	// hold, capture, then check one strap setting
	task automatic boot(input logic [2:0] m, input logic [2:0] f);
		logic [7:0] v;
		v = 8'($random(seed));
		hold     <= 1'b1;
		hold_src <= 2'($random(seed));
		mode_lvl <= m;
		fmt_lvl  <= f;
		rate_lvl <= 3'($random(seed));
		repeat (4) @(posedge clk);
		chk(device_in_reset === 1'b1 && config_valid === 1'b0, "hold");
		hold <= 1'b0;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (config_valid !== 1'b1 && n < 20);
		chk(config_valid === 1'b1, "run start");
		chk(sw_mode === (m == 3'h0) && device_in_reset === 1'b0, "mode");
		if (m == 3'h0) begin
			axw(OFS_PORT_CTRL, {24'h0, v});
			repeat (3) @(posedge clk);
			chk(rsp === RESP_OKAY && port_cfg === v, "sw cfg");
			axr(OFS_PORT_CTRL);
			chk(rd === {24'h0, v}, "ctrl read");
			axw(32'h8, 32'h0);
			chk(rsp === RESP_SLVERR, "bad write");
			axr(32'h8);
			chk(rsp === RESP_SLVERR && rd === 32'h0, "bad read");
		end else begin
			exp_cfg = expect_cfg(m, f);
			chk(port_cfg === exp_cfg, "hw cfg");
			mode_lvl <= ~m;
			fmt_lvl  <= ~f;
			repeat (5) @(posedge clk);
			chk(port_cfg === exp_cfg && config_valid === 1'b1, "frozen");
			chk(rate_detect_ok === (m == 3'h7 && rate_lvl <= 3'h6), "rate");
		end
		axr(OFS_PORT_STATUS);
		chk(rd[8:0] === {1'b0, m != 3'h0 && f inside {3'h3, 3'h4, 3'h5}, m == 3'h0, f, m},
			"status");
	endtask : boot
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : tally_and_finish
	// ==========
	// main sequence: every strap pair, then a reset in mid-run
	initial begin
		{error_cnt, checks_done, n} = 0;
		seed = 32'h9c99;
		{resetn, hold_src, mode_lvl, fmt_lvl, rate_lvl, s_axi_awvalid, s_axi_wvalid} = 0;
		{s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 0;
		hold = 1'b1;
		s_axi_wstrb = 4'hf;
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		for (int i = 0; i < 64; i++) begin
			boot(3'(i >> 3), 3'(i));
		end
		resetn <= 1'b0;
		repeat (2) @(posedge clk);
		chk(config_valid === 1'b0 && device_in_reset === 1'b1, "block reset");
		resetn <= 1'b1;
		axr(OFS_PORT_CTRL);
		chk(rd === 32'h0 && rsp === RESP_OKAY, "ctrl reset");
		boot(3'h7, 3'h7);
		tally_and_finish();
	end
	// hang guard
	initial begin
		#(50 * 20000);
		error_cnt++;
		tally_and_finish();
	end
endmodule : apscd_decoder_bench
bind apscd_decoder apscd_decoder_sva u_sva (.clk, .resetn, .reset_pin_n, .analog_supply_ok,
	.digital_supply_ok, .mode_rate_strap, .frame_format_strap, .detected_rate_code,
	.device_in_reset, .sw_mode, .config_valid, .format_invalid, .rate_detect_ok, .port_cfg,
	.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid);
`default_nettype wire

// ==== bench/apscd_decoder_sva.sv ====
// checker for the strap decoder, bound to apscd_decoder
// assumes straps stay steady from release until the run starts
`timescale 1ns/1ps
`default_nettype none
module apscd_decoder_sva
	import apscd_pkg::*;
(
	input wire logic               clk,
	input wire logic               resetn,
	input wire logic               reset_pin_n,
	input wire logic               analog_supply_ok,
	input wire logic               digital_supply_ok,
	input wire logic [2:0]         mode_rate_strap,
	input wire logic [2:0]         frame_format_strap,
	input wire logic [2:0]         detected_rate_code,
	input wire logic               device_in_reset,
	input wire logic               sw_mode,
	input wire logic               config_valid,
	input wire logic               format_invalid,
	input wire logic               rate_detect_ok,
	input wire apscd_port_cfg_type port_cfg,
	input wire logic [31:0]        s_axi_rdata,
	input wire logic [1:0]         s_axi_rresp,
	input wire logic               s_axi_rvalid
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	// ==========
	// run start, and run start in hardware mode
	sequence s_up; $rose(config_valid); endsequence
	sequence s_hw_up; s_up ##0 !sw_mode; endsequence
	property p_hold; !(reset_pin_n && analog_supply_ok && digital_supply_ok)
		|=> device_in_reset && !config_valid; endproperty
	a_hold: assert property (p_hold) else $error("hold ignored");
	property p_run; config_valid |-> !device_in_reset; endproperty
	a_run: assert property (p_run) else $error("running in reset");
	property p_sw; s_up |-> sw_mode == (mode_rate_strap == 3'h0)
		&& !(sw_mode && format_invalid); endproperty
	a_sw: assert property (p_sw) else $error("mode select wrong");
	property p_role; s_hw_up |-> port_cfg.role_secondary == mode_rate_strap[2]; endproperty
	a_role: assert property (p_role) else $error("port role wrong");
	property p_auto; s_hw_up |-> port_cfg.rate_autodetect == (mode_rate_strap == 3'h7); endproperty
	a_auto: assert property (p_auto) else $error("autodetect wrong");
	property p_rate; resetn |=> rate_detect_ok == ($past(port_cfg.rate_autodetect)
		&& $past(detected_rate_code) <= 3'h6); endproperty
	a_rate: assert property (p_rate) else $error("rate check wrong");
	property p_tdm; s_hw_up ##0 frame_format_strap inside {3'h1, 3'h2} |-> port_cfg.tdm_max_slots
		&& port_cfg.launch_rising == frame_format_strap[1]; endproperty
	a_tdm: assert property (p_tdm) else $error("tdm edge wrong");
	property p_inv; s_hw_up |-> format_invalid == (frame_format_strap inside {3'h3, 3'h4, 3'h5});
	endproperty
	a_inv: assert property (p_inv) else $error("reserved flag wrong");
	property p_frozen; config_valid && !sw_mode ##1 config_valid |-> $stable(port_cfg); endproperty
	a_frozen: assert property (p_frozen) else $error("config moved");
	property p_refuse; s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0; endproperty
	a_refuse: assert property (p_refuse) else $error("refused read data");
endmodule : apscd_decoder_sva
`default_nettype wire

// ==== bench/apscd_strap_model.sv ====
// straps, supply monitors and reset driver facing the decoder
// assumes the bench commands levels just after a rising edge
`timescale 1ns/1ps
`default_nettype none
module apscd_strap_model (
	input wire logic       clk,
	input wire logic       hold,       // request a device hold
	input wire logic [1:0] hold_src,   // 0 pin, 1 analog, 2 digital, 3 all
	input wire logic [2:0] mode_lvl,
	input wire logic [2:0] fmt_lvl,
	input wire logic [2:0] rate_lvl,   // 7 = rate not in the list
	output var logic       reset_pin_n,
	output var logic       analog_supply_ok,
	output var logic       digital_supply_ok,
	output var logic [2:0] mode_rate_strap,
	output var logic [2:0] frame_format_strap,
	output var logic [2:0] detected_rate_code
);
	// start held, all rails low
	initial begin
		{reset_pin_n, analog_supply_ok, digital_supply_ok} = 3'h0;
		{mode_rate_strap, frame_format_strap, detected_rate_code} = 9'h0;
	end
	// reset source and strap levels follow the bench command
	always @(posedge clk) begin
		reset_pin_n        <= !(hold && hold_src[0] == hold_src[1]);
		analog_supply_ok   <= !(hold && hold_src[0]);
		digital_supply_ok  <= !(hold && hold_src[1]);
		mode_rate_strap    <= mode_lvl;
		frame_format_strap <= fmt_lvl;
		// rate meter code follows the bench level, 7 standing for no supported rate
		detected_rate_code <= rate_lvl;
	end
endmodule : apscd_strap_model
`default_nettype wire

// ==== hdl/apscd_decoder.sv ====
// audio port strap configuration decoder with an AXI4-Lite register slave
// holds the reset sequencer, strap capture, strap decode and two registers
// assumes strap codes, reset pin and supply monitors are synchronous to clk
// assumes each strap arrives already digitised as one 3-bit level code
// assumes the bus master keeps at most one write and one read under way
`timescale 1ns/1ps
`default_nettype none
module apscd_decoder
	import apscd_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        resetn,
	// device pins and monitors
	input  wire logic        reset_pin_n,        // device reset pin, active low
	input  wire logic        analog_supply_ok,   // analog rail above threshold
	input  wire logic        digital_supply_ok,  // digital rail above threshold
	input  wire logic [2:0]  mode_rate_strap,    // digitised level code
	input  wire logic [2:0]  frame_format_strap, // digitised level code
	input  wire logic [2:0]  detected_rate_code, // rate measured by autodetect
	// decoded configuration
	output logic             device_in_reset,
	output logic             sw_mode,
	output logic             config_valid,
	output logic             format_invalid,
	output logic             rate_detect_ok,
	output apscd_port_cfg_type port_cfg,
	// AXI4-Lite slave
	input  wire logic [31:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [31:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);
	// ==========================================================
	// internal state
	apscd_state_type    state;         // reset sequencer
	logic               hold_now;      // any reset source active
	logic [2:0]         cap_mode;      // captured mode strap level
	logic [2:0]         cap_fmt;       // captured format strap level
	apscd_port_cfg_type hw_cfg;        // decoded strap configuration
	apscd_port_cfg_type ctrl_reg;      // software configuration register
	apscd_port_cfg_type next_cfg;      // configuration to present
	logic [31:0]        aw_addr;       // latched write address
	logic [31:0]        w_data;        // latched write data
	logic [3:0]         w_strb;        // latched write strobes
	logic               aw_have;       // write address held
	logic               w_have;        // write data held
	logic               do_write;      // both halves present
	logic [31:0]        status_word;   // read view of block state

	// ==========================================================
	// address decode
	// a register is hit only by its own aligned word address; the write
	// strobe, the write response and the read mux all use this one test,
	// so a refused address can never slip through one of them
	function automatic logic apscd_word_hit(input logic [31:0] addr,
		input logic [31:0] ofs);
		return (addr[31:2] == ofs[31:2]) && (addr[1:0] == 2'h0);
	endfunction : apscd_word_hit

	// ==========================================================
	// reset sources
	// pin or either supply monitor keeps the device held
	// the hold is a level: the sequencer stays in hold as long as it lasts
	assign hold_now = !reset_pin_n || !analog_supply_ok || !digital_supply_ok;

	// sequencer: hold, capture once on release, then run
	// the capture state sits between release and run so the straps are
	// sampled only once every hold source has let go
	// a new hold at any point sends it straight back to the start
	always_ff @(posedge clk) begin
		if (!resetn) begin
			state <= ST_HOLD;
		end else if (hold_now) begin
			state <= ST_HOLD;
		end else begin
			unique case (state)
				ST_HOLD:    state <= ST_CAPTURE;
				ST_CAPTURE: state <= ST_RUN;
				ST_RUN:     state <= ST_RUN;
				// the unused code falls back to hold and starts a fresh capture
				default:    state <= ST_HOLD;
			endcase
		end
	end

	// strap capture happens only in the capture cycle after release
	// the reset value of the mode level means software mode, so nothing
	// is driven from straps before the first capture
	always_ff @(posedge clk) begin
		if (!resetn) begin
			cap_mode <= LVL_PU_0R;
			cap_fmt  <= LVL_PD_0R;
		end else if (state == ST_CAPTURE) begin
			cap_mode <= mode_rate_strap;
			cap_fmt  <= frame_format_strap;
		end
	end

	// ==========================================================
	// decode
	// captured levels are decoded continuously, so the result stays frozen
	// while running: later strap changes only reach it through a new hold
	// the mode level picks role and rate, the format level the framing
	always_comb begin
		hw_cfg = apscd_dec_fmt(apscd_dec_mode(PORT_CTRL_RESET, cap_mode), cap_fmt);
	end

	// hardware mode takes the straps, software mode the control register
	// the choice follows the captured mode level, never the live strap
	always_comb begin
		if (apscd_is_sw(cap_mode)) begin
			next_cfg = ctrl_reg;
		end else begin
			next_cfg = hw_cfg;
		end
	end

	// presented configuration and flags, updated only while running
	// outside the run the last values stay on the pins and config_valid
	// tells the far side not to trust them
	always_ff @(posedge clk) begin
		if (!resetn) begin
			port_cfg       <= PORT_CTRL_RESET;
			sw_mode        <= 1'b0;
			format_invalid <= 1'b0;
			config_valid   <= 1'b0;
		end else begin
			config_valid <= (state == ST_RUN) && !hold_now;
			if (state == ST_RUN) begin
				port_cfg       <= next_cfg;
				sw_mode        <= apscd_is_sw(cap_mode);
				// reserved format levels only matter in hardware mode
				format_invalid <= !apscd_is_sw(cap_mode) &&
					(hw_cfg.frame_format == FMT_NONE);
			end
		end
	end

	// reset indication follows the sequencer
	// high from the first held edge until the run has begun
	// while resetn is low it reads as held as well
	always_ff @(posedge clk) begin
		if (!resetn) begin
			device_in_reset <= 1'b1;
		end else begin
			device_in_reset <= hold_now || (state != ST_RUN);
		end
	end

	// autodetect result is good only for the seven supported rates
	// code 7 from the rate meter means no supported rate was found
	// the check reads the presented configuration, so it lags by one edge
	always_ff @(posedge clk) begin
		if (!resetn) begin
			rate_detect_ok <= 1'b0;
		end else begin
			rate_detect_ok <= port_cfg.rate_autodetect &&
				(detected_rate_code <= RATE_CODE_MAX);
		end
	end

	// ==========================================================
	// AXI4-Lite write path
	// register map: control word at 0x0 (read/write, low byte only) and
	// status word at 0x4 (read only, a write is answered and dropped);
	// any other or misaligned address is refused with an error response
	// and leaves both registers untouched
	// the write is carried out once both halves are held and no response
	// is still waiting for the master
	assign do_write = aw_have && w_have && !s_axi_bvalid;

	// write address channel, one at a time
	// the address is held until the response has been taken
	always_ff @(posedge clk) begin
		if (!resetn) begin
			s_axi_awready <= 1'b1;
			aw_have       <= 1'b0;
			aw_addr       <= 32'h0000_0000;
		end else if (s_axi_awvalid && s_axi_awready) begin
			// take the address and close the channel until the response
			s_axi_awready <= 1'b0;
			aw_have       <= 1'b1;
			aw_addr       <= s_axi_awaddr;
		end else if (s_axi_bvalid && s_axi_bready) begin
			// response taken: reopen for the next address
			s_axi_awready <= 1'b1;
			aw_have       <= 1'b0;
		end
	end

	// write data channel, independent of the address order
	// data may arrive before, with or after its address
	always_ff @(posedge clk) begin
		if (!resetn) begin
			s_axi_wready <= 1'b1;
			w_have       <= 1'b0;
			w_data       <= 32'h0000_0000;
			w_strb       <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			// take data and strobes and close the channel until the response
			s_axi_wready <= 1'b0;
			w_have       <= 1'b1;
			w_data       <= s_axi_wdata;
			w_strb       <= s_axi_wstrb;
		end else if (s_axi_bvalid && s_axi_bready) begin
			// response taken: reopen for the next data beat
			s_axi_wready <= 1'b1;
			w_have       <= 1'b0;
		end
	end

	// control register, low byte lane only
	// a write without the low byte strobe is answered but changes nothing
	always_ff @(posedge clk) begin
		if (!resetn) begin
			ctrl_reg <= PORT_CTRL_RESET;
		end else if (do_write && apscd_word_hit(aw_addr, OFS_PORT_CTRL) && w_strb[0]) begin
			ctrl_reg <= w_data[7:0];
		end
	end

	// write response, error for unmapped words
	// bvalid and bresp stand until the master raises bready
	always_ff @(posedge clk) begin
		if (!resetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			if (apscd_word_hit(aw_addr, OFS_PORT_CTRL) ||
				apscd_word_hit(aw_addr, OFS_PORT_STATUS)) begin
				// mapped word: accepted, even when it is the read-only one
				s_axi_bresp <= RESP_OKAY;
			end else begin
				// unmapped or misaligned: refused
				s_axi_bresp <= RESP_SLVERR;
			end
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ==========================================================
	// AXI4-Lite read path
	// status word built from the block's own state
	// bits 2:0 captured mode level, bits 5:3 captured format level,
	// bit 6 software mode, bit 7 reserved format level, bit 8 held in
	// reset, bit 9 supported rate detected; other bits read as zero
	always_comb begin
		status_word                            = 32'h0000_0000;
		status_word[ST_MODE_LSB +: 3]          = cap_mode;
		status_word[ST_FMT_LSB +: 3]           = cap_fmt;
		status_word[ST_SW]                     = sw_mode;
		status_word[ST_INVALID]                = format_invalid;
		status_word[ST_INRESET]                = device_in_reset;
		status_word[ST_RATEOK]                 = rate_detect_ok;
	end

	// read address, data and response
	// the answer is registered on the same edge that takes the address and
	// stands until the master takes it; the address channel stays shut
	always_ff @(posedge clk) begin
		if (!resetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			if (apscd_word_hit(s_axi_araddr, OFS_PORT_CTRL)) begin
				// control word, upper bits read as zero
				s_axi_rdata <= {24'h00_0000, ctrl_reg};
				s_axi_rresp <= RESP_OKAY;
			end else if (apscd_word_hit(s_axi_araddr, OFS_PORT_STATUS)) begin
				// status word, live view
				s_axi_rdata <= status_word;
				s_axi_rresp <= RESP_OKAY;
			end else begin
				s_axi_rdata <= 32'h0000_0000; // unmapped
				s_axi_rresp <= RESP_SLVERR;
			end
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
		end
	end
endmodule : apscd_decoder
`default_nettype wire

// ==== hdl/apscd_pkg.sv ====
// constants, types and strap decode functions for the strap configuration decoder
// assumes strap levels arrive already digitised as a 3-bit level code
package apscd_pkg;
	// ==========================================================
	// strap level codes (0..3 pull-up strong to weak, 4..7 pull-down weak to strong)
	localparam logic [2:0] LVL_PU_0R   = 3'h0;
	localparam logic [2:0] LVL_PU_4K7  = 3'h1;
	localparam logic [2:0] LVL_PU_22K  = 3'h2;
	localparam logic [2:0] LVL_PU_100K = 3'h3;
	localparam logic [2:0] LVL_PD_100K = 3'h4;
	localparam logic [2:0] LVL_PD_22K  = 3'h5;
	localparam logic [2:0] LVL_PD_4K7  = 3'h6;
	localparam logic [2:0] LVL_PD_0R   = 3'h7;

	// ==========================================================
	// rate families and frame formats
	localparam logic [1:0] RATE_48K  = 2'h0;
	localparam logic [1:0] RATE_96K  = 2'h1;
	localparam logic [1:0] RATE_192K = 2'h2;
	localparam logic [1:0] FMT_TDM   = 2'h0;
	localparam logic [1:0] FMT_LJ    = 2'h1;
	localparam logic [1:0] FMT_I2S   = 2'h2;
	localparam logic [1:0] FMT_NONE  = 2'h3;
	// detected rate codes 0..6 are 32,44.1,48,88.2,96,176.4,192 kHz
	localparam logic [2:0] RATE_CODE_MAX = 3'h6;

	// ==========================================================
	// register map
	localparam logic [31:0] OFS_PORT_CTRL   = 32'h0000_0000;
	localparam logic [31:0] OFS_PORT_STATUS = 32'h0000_0004;
	localparam logic [7:0]  PORT_CTRL_RESET = 8'h00;
	localparam logic [1:0]  RESP_OKAY       = 2'h0;
	localparam logic [1:0]  RESP_SLVERR     = 2'h2;
	// status field positions
	localparam int ST_MODE_LSB = 0;
	localparam int ST_FMT_LSB  = 3;
	localparam int ST_SW       = 6;
	localparam int ST_INVALID  = 7;
	localparam int ST_INRESET  = 8;
	localparam int ST_RATEOK   = 9;

	// audio serial port configuration, layout equals the control register byte
	typedef struct packed {
		logic       launch_rising;  // bit 7
		logic       tdm_max_slots;  // bit 6
		logic [1:0] frame_format;   // bits 5:4
		logic       rate_autodetect;// bit 3
		logic [1:0] rate_family;    // bits 2:1
		logic       role_secondary; // bit 0
	} apscd_port_cfg_type;

	typedef enum logic [1:0] {
		ST_HOLD    = 2'b00,
		ST_CAPTURE = 2'b01,
		ST_RUN     = 2'b11
	} apscd_state_type;

	// strongest pull-up on the mode strap means software control
	function automatic logic apscd_is_sw(input logic [2:0] lvl);
		return lvl == LVL_PU_0R;
	endfunction : apscd_is_sw

	// mode-and-rate strap to role and rate family
	function automatic apscd_port_cfg_type apscd_dec_mode(input apscd_port_cfg_type base,
		input logic [2:0] lvl);
		apscd_port_cfg_type c;
		c = base;
		c.role_secondary  = lvl[2];
		c.rate_autodetect = 1'b0;
		unique case (lvl)
			LVL_PU_0R:   c.rate_family = RATE_48K;
			LVL_PU_4K7:  c.rate_family = RATE_48K;
			LVL_PU_22K:  c.rate_family = RATE_96K;
			LVL_PU_100K: c.rate_family = RATE_192K;
			LVL_PD_100K: c.rate_family = RATE_192K;
			LVL_PD_22K:  c.rate_family = RATE_96K;
			LVL_PD_4K7:  c.rate_family = RATE_48K;
			LVL_PD_0R: begin
				c.rate_family     = RATE_48K;
				c.rate_autodetect = 1'b1;
			end
		endcase
		return c;
	endfunction : apscd_dec_mode

	// format strap to framing, slot count and launch edge
	function automatic apscd_port_cfg_type apscd_dec_fmt(input apscd_port_cfg_type base,
		input logic [2:0] lvl);
		apscd_port_cfg_type c;
		c = base;
		c.tdm_max_slots = 1'b0;
		c.launch_rising = 1'b0;
		unique case (lvl)
			LVL_PU_0R:  c.frame_format = FMT_TDM;
			LVL_PU_4K7: begin
				c.frame_format  = FMT_TDM;
				c.tdm_max_slots = 1'b1;
			end
			LVL_PU_22K: begin
				c.frame_format  = FMT_TDM;
				c.tdm_max_slots = 1'b1;
				c.launch_rising = 1'b1;
			end
			LVL_PD_4K7: c.frame_format = FMT_LJ;
			LVL_PD_0R:  c.frame_format = FMT_I2S;
			default:    c.frame_format = FMT_NONE;
		endcase
		return c;
	endfunction : apscd_dec_fmt
endpackage : apscd_pkg
